/* File: rtl/nv_defs.svh */
// offsets, field positions, reset values and counts of the nv control block
`ifndef NV_DEFS_SVH
`define NV_DEFS_SVH
// Summary of operation
// - only one data half mapped at once
// - sector_mode 0 splits sector, four per page
// - split-mode erase clears all eight bytes
// - sector_mode 1 keeps whole sector in page
// - whole-mode erase clears foreground sector only
// - divider bit 7 status, bits 6:0 write-once
// - no erase or program before divider written
// - reset copies two nonvolatile options into registers
// - security code 2'b10 unsecured, others secured
// - secured blocks memory access from unsecured sources
// - key match or blank check unsecures
// - data_page_select picks foreground page
// - key_access_enable steers key-window writes
// - eight-byte backdoor key compared to writes

// register offsets on the register port
`define NV_OFS_CLOCK_DIVIDER 8'h00
`define NV_OFS_OPTION_COPY 8'h01
`define NV_OFS_CONFIGURATION 8'h02
`define NV_OFS_PROTECT_COPY 8'h03
`define NV_OFS_STATUS 8'h04
// field positions
`define NV_DIV_LOADED_BIT 7
`define NV_SECTOR_MODE_BIT 5
`define NV_PAGE_SELECT_BIT 6
`define NV_KEY_ACCESS_BIT 5
`define NV_STAT_REFUSED_BIT 0
`define NV_STAT_KEY_FAIL_BIT 1
// values and masks
`define NV_SEC_UNSECURED 2'h2
`define NV_OPTION_RESET 8'h00
`define NV_CONFIG_RESET 8'h00
`define NV_CONFIG_MASK 8'h60
`define NV_ERASED_BYTE 8'hFF
`define NV_KEY_BYTES 8
`endif

/* File: rtl/nv_pkg.sv */
// types shared by the nv control block and its submodules
package nv_pkg;
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    // data memory window request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic prog;
        logic erase;
        logic unsecured_src;
    } data_req_t;
    // write into the eight-byte key window
    typedef struct packed {
        logic [2:0] index;
        logic [7:0] wdata;
        logic wr;
    } key_req_t;
    // key comparison states
    typedef enum logic [1:0] {KEY_IDLE, KEY_COLLECT, KEY_CHECK} key_state_t;
endpackage

/* File: rtl/nv_byte_array.sv */
// data memory array with byte program and eight-byte sector erase
`timescale 1ns/1ps
`include "nv_defs.svh"
module nv_byte_array #(
    parameter int AW = 9
) (
    // clock
    input wire logic clk,
    // read side
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data,
    // program side
    input wire logic prog,
    input wire logic [AW-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    // erase side, base is sector aligned
    input wire logic erase,
    input wire logic [AW-1:0] erase_base
);
    logic [7:0] mem [0:(1<<AW)-1]; // both pages, nonvolatile contents

    // combinational read, caller registers it
    assign rd_data = mem[rd_addr];

    // programming only clears bits; erase sets a sector to all ones
    always_ff @(posedge clk) begin
        if (erase) begin
            for (int i = 0; i < `NV_KEY_BYTES; i++) begin
                mem[erase_base + AW'(i)] <= `NV_ERASED_BYTE;
            end
        end else if (prog) begin
            mem[prog_addr] <= mem[prog_addr] & prog_data;
        end
    end
endmodule

/* File: rtl/nv_key_compare.sv */
// collects eight key bytes and compares them with the stored backdoor key
`timescale 1ns/1ps
module nv_key_compare (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // key writes
    input wire logic enable,
    input wire nv_pkg::key_req_t key_req,
    input wire logic [63:0] backdoor_compare_key,
    // result pulses
    output logic match,
    output logic mismatch
);
    nv_pkg::key_state_t state_reg; // collect or check
    logic [63:0] buf_reg; // bytes written so far
    logic [7:0] seen_reg; // which indexes arrived

    // gather bytes, compare once all eight are present
    always_ff @(posedge clk) begin
        match <= 1'b0;
        mismatch <= 1'b0;
        if (!reset_n || !enable) begin
            state_reg <= nv_pkg::KEY_IDLE;
            seen_reg <= 8'h00;
            buf_reg <= 64'h0;
        end else begin
            case (state_reg)
                nv_pkg::KEY_IDLE, nv_pkg::KEY_COLLECT: begin
                    if (key_req.wr) begin
                        buf_reg[key_req.index*8 +: 8] <= key_req.wdata;
                        seen_reg[key_req.index] <= 1'b1;
                        state_reg <= (&(seen_reg | (8'h01 << key_req.index))) ?
                            nv_pkg::KEY_CHECK : nv_pkg::KEY_COLLECT;
                    end
                end
                nv_pkg::KEY_CHECK: begin
                    match <= (buf_reg == backdoor_compare_key);
                    mismatch <= (buf_reg != backdoor_compare_key);
                    seen_reg <= 8'h00;
                    state_reg <= nv_pkg::KEY_IDLE;
                end
                default: state_reg <= nv_pkg::KEY_IDLE;
            endcase
        end
    end
endmodule

/* File: rtl/nv_control.sv */
// nonvolatile page mapping, write-once divider, security and option copy
`timescale 1ns/1ps
`include "nv_defs.svh"
module nv_control (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire nv_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // data memory window
    input wire nv_pkg::data_req_t data_req,
    output logic [7:0] data_rdata,
    // key window writes
    input wire nv_pkg::key_req_t key_req,
    // nonvolatile locations; option and protect bytes read at reset, backdoor key read at each compare
    input wire logic [7:0] nv_option_byte,
    input wire logic [7:0] nv_protect_byte,
    input wire logic [63:0] backdoor_compare_key,
    // program memory controller events
    input wire logic blank_check_pass,
    // program memory command start
    output logic cmd_start,
    output logic [2:0] cmd_index,
    output logic [7:0] cmd_data,
    // status toward the system
    output logic [6:0] nv_clock_div,
    output logic secured
);
    // register state
    logic [6:0] div_reg; // divider value
    logic div_loaded_reg; // divider has been written once
    logic [7:0] option_reg; // option copy, holds sector_mode and security_state
    logic [7:0] protect_reg; // second copied location
    logic [7:0] config_reg; // page select and key access
    logic [1:0] status_reg; // sticky refused and key-fail flags
    logic copy_pending_reg; // reset copy still to do
    // output flops
    logic [7:0] rdata_reg;
    logic [7:0] drdata_reg;
    logic cmd_start_reg;
    logic [2:0] cmd_index_reg;
    logic [7:0] cmd_data_reg;
    logic secured_reg;

    // decoded fields
    logic sector_mode; // 1 keeps a whole sector in one page
    logic data_page_select; // foreground page
    logic key_access_enable; // key window loads key bytes
    logic [1:0] security_state; // two-bit security code
    logic is_secured; // any code but the unsecured one
    logic access_ok; // data access not blocked
    logic nvm_ok; // erase and program allowed
    logic [8:0] phys_addr; // foreground address to array address
    logic [8:0] erase_base; // first byte of the erased sector
    logic [7:0] array_rdata; // raw array read
    logic do_prog; // accepted program
    logic do_erase; // accepted erase
    logic refuse_evt; // an access was refused this cycle
    logic key_match; // backdoor key accepted
    logic key_mismatch; // backdoor key rejected
    logic key_load; // key window write loads a key byte
    logic cmd_evt; // key window write starts a command
    logic stat_wr; // software write to status

    // field extraction
    assign sector_mode = option_reg[`NV_SECTOR_MODE_BIT];
    assign data_page_select = config_reg[`NV_PAGE_SELECT_BIT];
    assign key_access_enable = config_reg[`NV_KEY_ACCESS_BIT];
    assign security_state = option_reg[1:0];

    // only code 2'b10 means unsecured
    assign is_secured = (security_state != `NV_SEC_UNSECURED);

    // unsecured sources see nothing while secured
    assign access_ok = !(is_secured && data_req.unsecured_src);

    // erase and program wait for the divider write
    assign nvm_ok = access_ok && div_loaded_reg;

    // map the foreground window onto the two-page array
    always_comb begin
        if (sector_mode) begin
            // whole sector in one page, page picks which sectors are seen
            phys_addr = {data_page_select, data_req.addr};
            erase_base = {data_page_select, data_req.addr[7:3], 3'h0};
        end else begin
            // four bytes per page at the same address
            phys_addr = {data_req.addr[7:2], data_page_select, data_req.addr[1:0]};
            erase_base = {data_req.addr[7:2], 3'h0};
        end
    end

    // accepted operations and refusals
    assign do_prog = data_req.prog && nvm_ok;
    assign do_erase = data_req.erase && nvm_ok;
    assign key_load = key_req.wr && key_access_enable;
    assign cmd_evt = key_req.wr && !key_access_enable && div_loaded_reg;
    assign refuse_evt = ((data_req.prog || data_req.erase) && !nvm_ok) ||
        (data_req.rd && !access_ok) ||
        (key_req.wr && !key_access_enable && !div_loaded_reg);
    assign stat_wr = reg_req.wr && (reg_req.addr == `NV_OFS_STATUS);

    // two-page array
    nv_byte_array #(
        .AW(9)
    ) u_array (
        .clk(clk),
        .rd_addr(phys_addr),
        .rd_data(array_rdata),
        .prog(do_prog),
        .prog_addr(phys_addr),
        .prog_data(data_req.wdata),
        .erase(do_erase),
        .erase_base(erase_base)
    );

    // backdoor key comparison
    nv_key_compare u_key (
        .clk(clk),
        .reset_n(reset_n),
        .enable(key_access_enable),
        .key_req(key_load ? key_req : '0),
        .backdoor_compare_key(backdoor_compare_key),
        .match(key_match),
        .mismatch(key_mismatch)
    );

    // divider: one write after reset, then locked
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_reg <= 7'h00;
            div_loaded_reg <= 1'b0;
        end else if (reg_req.wr && (reg_req.addr == `NV_OFS_CLOCK_DIVIDER)
                     && !div_loaded_reg) begin
            // first write takes, later ones are ignored
            div_reg <= reg_req.wdata[6:0];
            div_loaded_reg <= 1'b1;
        end
    end

    // reset copy flag, copy happens on the first edge after release
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            copy_pending_reg <= 1'b1;
        end else begin
            copy_pending_reg <= 1'b0;
        end
    end

    // option copy: loaded from nonvolatile, security field updates
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            option_reg <= `NV_OPTION_RESET;
            protect_reg <= `NV_OPTION_RESET;
        end else if (copy_pending_reg) begin
            // copy two nonvolatile locations into control registers
            option_reg <= nv_option_byte;
            protect_reg <= nv_protect_byte;
        end else if (key_match || blank_check_pass) begin
            // key match or blank program memory unsecures
            option_reg[1:0] <= `NV_SEC_UNSECURED;
        end
    end

    // configuration register, writable bits only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            config_reg <= `NV_CONFIG_RESET;
        end else if (reg_req.wr && (reg_req.addr == `NV_OFS_CONFIGURATION)) begin
            config_reg <= reg_req.wdata & `NV_CONFIG_MASK;
        end
    end

    // sticky status, write one clears, a new event wins over the clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_reg <= 2'h0;
        end else begin
            // refused flag
            if (refuse_evt) begin
                status_reg[`NV_STAT_REFUSED_BIT] <= 1'b1;
            end else if (stat_wr && reg_req.wdata[`NV_STAT_REFUSED_BIT]) begin
                status_reg[`NV_STAT_REFUSED_BIT] <= 1'b0;
            end
            // key mismatch flag
            if (key_mismatch) begin
                status_reg[`NV_STAT_KEY_FAIL_BIT] <= 1'b1;
            end else if (stat_wr && reg_req.wdata[`NV_STAT_KEY_FAIL_BIT]) begin
                status_reg[`NV_STAT_KEY_FAIL_BIT] <= 1'b0;
            end
        end
    end

    // register read data, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                // status bit on top, value below
                `NV_OFS_CLOCK_DIVIDER: rdata_reg <= {div_loaded_reg, div_reg};
                `NV_OFS_OPTION_COPY: rdata_reg <= option_reg;
                `NV_OFS_CONFIGURATION: rdata_reg <= config_reg;
                `NV_OFS_PROTECT_COPY: rdata_reg <= protect_reg;
                `NV_OFS_STATUS: rdata_reg <= {6'h00, status_reg};
                // unmapped offsets read zero
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // data window read, zero when blocked
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            drdata_reg <= 8'h00;
        end else if (data_req.rd && access_ok) begin
            drdata_reg <= array_rdata;
        end else begin
            drdata_reg <= 8'h00;
        end
    end

    // command start toward program memory
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cmd_start_reg <= 1'b0;
            cmd_index_reg <= 3'h0;
            cmd_data_reg <= 8'h00;
        end else begin
            cmd_start_reg <= cmd_evt;
            if (cmd_evt) begin
                cmd_index_reg <= key_req.index;
                cmd_data_reg <= key_req.wdata;
            end
        end
    end

    // security level toward RAM and program memory gates
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            secured_reg <= 1'b1;
        end else begin
            secured_reg <= is_secured;
        end
    end

    // outputs
    assign reg_rdata = rdata_reg;
    assign data_rdata = drdata_reg;
    assign cmd_start = cmd_start_reg;
    assign cmd_index = cmd_index_reg;
    assign cmd_data = cmd_data_reg;
    assign nv_clock_div = div_reg;
    assign secured = secured_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // a divider write after it is loaded
    sequence s_late_div_write;
        div_loaded_reg && reg_req.wr && (reg_req.addr == `NV_OFS_CLOCK_DIVIDER);
    endsequence
    // an unsecured source reads while secured
    sequence s_blocked_read;
        data_req.rd && data_req.unsecured_src && is_secured;
    endsequence
    // a key window write in command mode
    sequence s_cmd_write;
        key_req.wr && !key_access_enable;
    endsequence

    AST_DIV_LOCKED: assert property (
        s_late_div_write |=> $stable(div_reg) && div_loaded_reg)
        else $error("divider changed after its single write");
    AST_REFUSE_UNLOADED: assert property (
        (data_req.prog || data_req.erase) && !div_loaded_reg
        |=> status_reg[`NV_STAT_REFUSED_BIT])
        else $error("program or erase not refused before divider write");
    AST_RESET_COPY: assert property (
        copy_pending_reg |=> option_reg == $past(nv_option_byte)
        && protect_reg == $past(nv_protect_byte))
        else $error("options not copied after reset");
    AST_SECURE_OUT: assert property (
        !copy_pending_reg ##1 1'b1 |-> secured_reg == ($past(security_state) != 2'h2))
        else $error("secured output does not follow the code");
    AST_BLOCK_READ: assert property (
        s_blocked_read |=> data_rdata == 8'h00 && status_reg[`NV_STAT_REFUSED_BIT])
        else $error("secured read was not blocked");
    AST_UNSECURE: assert property (
        (key_match || blank_check_pass) && !copy_pending_reg
        |=> security_state == 2'h2 ##1 !secured_reg)
        else $error("unsecure event did not clear security");
    AST_CMD_START: assert property (
        s_cmd_write ##0 div_loaded_reg |=> cmd_start && cmd_data == $past(key_req.wdata))
        else $error("command start missing");
    AST_KEY_NO_CMD: assert property (
        key_req.wr && key_access_enable |=> !cmd_start)
        else $error("key load started a command");
    AST_PAGE_READ: assert property (
        reg_req.rd && reg_req.addr == `NV_OFS_CONFIGURATION
        |=> reg_rdata[`NV_PAGE_SELECT_BIT] == $past(data_page_select))
        else $error("page select readback wrong");

    // mapping, gate and key checks
    // a failed key comparison
    sequence s_key_fail;
        key_mismatch;
    endsequence
    // command write, divider unset
    sequence s_early_cmd;
        key_req.wr && !key_access_enable && !div_loaded_reg;
    endsequence
    // outside change while secured
    sequence s_blocked_nvm;
        (data_req.prog || data_req.erase) && data_req.unsecured_src && is_secured;
    endsequence

    // failed key sets its flag
    AST_KEY_FAIL_FLAG: assert property (
        s_key_fail |=> status_reg[`NV_STAT_KEY_FAIL_BIT])
        else $error("key mismatch not flagged");
    // no command before divider
    AST_EARLY_CMD: assert property (
        s_early_cmd |=> !cmd_start && status_reg[`NV_STAT_REFUSED_BIT])
        else $error("command before divider write");
    // secured array left alone
    AST_BLOCK_NVM: assert property (
        s_blocked_nvm |-> (!do_prog && !do_erase) ##1 status_reg[`NV_STAT_REFUSED_BIT])
        else $error("secured change not refused");
    // split erase spans both pages
    AST_SPLIT_ERASE: assert property (
        do_erase && !sector_mode
        |-> erase_base[2:0] == 3'h0 && erase_base[8:3] == data_req.addr[7:2])
        else $error("split erase misses a half");
    // whole erase stays in front
    AST_WHOLE_ERASE: assert property (
        do_erase && sector_mode
        |-> erase_base[2:0] == 3'h0 && erase_base[8] == data_page_select)
        else $error("whole erase left its page");
    // page bit placed by mode
    AST_PAGE_BIT: assert property (
        (sector_mode ? phys_addr[8] : phys_addr[2]) == data_page_select)
        else $error("page select not in address");
    // allowed read returns byte
    AST_PAGE_WINDOW: assert property (
        data_req.rd && access_ok |=> data_rdata == $past(array_rdata))
        else $error("foreground byte not returned");
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the nv control block
`timescale 1ns/1ps
`include "nv_defs.svh"
module tb;
    // clock and reset
    logic clk;
    logic reset_n;
    // requests toward the block
    nv_pkg::reg_req_t reg_req;
    nv_pkg::data_req_t data_req;
    nv_pkg::key_req_t key_req;
    // nonvolatile inputs
    logic [7:0] nv_option_byte;
    logic [7:0] nv_protect_byte;
    logic [63:0] backdoor_compare_key;
    logic blank_check_pass;
    // observed outputs
    logic [7:0] reg_rdata;
    logic [7:0] data_rdata;
    logic cmd_start;
    logic [2:0] cmd_index;
    logic [7:0] cmd_data;
    logic [6:0] nv_clock_div;
    logic secured;
    // counters and scratch
    int num_errors;
    int check_count;
    logic [7:0] rd_val;
    // data window kinds as {rd, prog, erase}
    localparam logic [2:0] RD = 3'h4;
    localparam logic [2:0] PG = 3'h2;
    localparam logic [2:0] ER = 3'h1;
    // one register step and the read value it should give
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } reg_row_t;
    reg_row_t rows [16];

    nv_control nv_control_inst (
        .clk(clk),
        .reset_n(reset_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .data_req(data_req),
        .data_rdata(data_rdata),
        .key_req(key_req),
        .nv_option_byte(nv_option_byte),
        .nv_protect_byte(nv_protect_byte),
        .backdoor_compare_key(backdoor_compare_key),
        .blank_check_pass(blank_check_pass),
        .cmd_start(cmd_start),
        .cmd_index(cmd_index),
        .cmd_data(cmd_data),
        .nv_clock_div(nv_clock_div),
        .secured(secured)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compares one byte, counts it
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %2h seen %2h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one-cycle register write
    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk);
        reg_req <= '{addr: addr, wdata: wdata, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req <= '0;
    endtask

    // register read, data taken the cycle after the strobe
    task automatic reg_expect(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk);
        reg_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req <= '0;
        #1;
        check8("register", exp, reg_rdata);
    endtask

    // one data window operation, read byte returned
    task automatic data_op(input logic [2:0] kind, input logic [7:0] addr,
        input logic [7:0] wdata, input logic src, output logic [7:0] val);
        @(posedge clk);
        data_req <= '{addr: addr, wdata: wdata, rd: kind[2], prog: kind[1],
            erase: kind[0], unsecured_src: src};
        @(posedge clk);
        data_req <= '0;
        #1 val = data_rdata;
    endtask

    // data window read against an expected byte
    task automatic mem_expect(input logic [7:0] addr, input logic src, input logic [7:0] exp);
        logic [7:0] v;
        data_op(RD, addr, 8'h00, src, v);
        check8("data byte", exp, v);
    endtask

    // key window write, command start flag returned
    task automatic key_wr(input logic [2:0] idx, input logic [7:0] wdata, output logic [7:0] st);
        @(posedge clk);
        key_req <= '{index: idx, wdata: wdata, wr: 1'b1};
        @(posedge clk);
        key_req <= '0;
        #1 st = {7'h00, cmd_start};
    endtask

    // synchronous reset held 16 cycles with a given option byte
    task automatic do_reset(input logic [7:0] opt);
        @(posedge clk);
        reset_n <= 1'b0;
        nv_option_byte <= opt;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // bounded wait for the secured flag to drop
    task automatic wait_unsecured();
        int n;
        n = 0;
        while (secured !== 1'b0 && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        check8("secured", 8'h00, {7'h00, secured});
        if (n >= 12) begin
            final_report();
        end
    endtask

    // main sequence
    initial begin
        reset_n = 1'b0;
        reg_req = '0;
        data_req = '0;
        key_req = '0;
        nv_option_byte = 8'h01;
        nv_protect_byte = 8'h5A;
        backdoor_compare_key = 64'h0123456789ABCDEF;
        blank_check_pass = 1'b0;
        num_errors = 0;
        check_count = 0;
        rows = '{'{1'b0, `NV_OFS_OPTION_COPY, 8'h00, 8'h01},
            '{1'b0, `NV_OFS_PROTECT_COPY, 8'h00, 8'h5A},
            '{1'b0, `NV_OFS_CONFIGURATION, 8'h00, 8'h00},
            '{1'b0, `NV_OFS_CLOCK_DIVIDER, 8'h00, 8'h00},
            '{1'b0, `NV_OFS_STATUS, 8'h00, 8'h00},
            '{1'b1, `NV_OFS_OPTION_COPY, 8'hFF, 8'h00},
            '{1'b0, `NV_OFS_OPTION_COPY, 8'h00, 8'h01},
            '{1'b0, 8'h07, 8'h00, 8'h00},
            '{1'b1, `NV_OFS_CONFIGURATION, 8'hFF, 8'h00},
            '{1'b0, `NV_OFS_CONFIGURATION, 8'h00, 8'h60},
            '{1'b1, `NV_OFS_CLOCK_DIVIDER, 8'h13, 8'h00},
            '{1'b0, `NV_OFS_CLOCK_DIVIDER, 8'h00, 8'h93},
            '{1'b1, `NV_OFS_CLOCK_DIVIDER, 8'h05, 8'h00},
            '{1'b0, `NV_OFS_CLOCK_DIVIDER, 8'h00, 8'h93},
            '{1'b1, `NV_OFS_CONFIGURATION, 8'h00, 8'h00},
            '{1'b0, `NV_OFS_CONFIGURATION, 8'h00, 8'h00}};
        // security code 01, split sectors
        do_reset(8'h01);
        check8("secured", 8'h01, {7'h00, secured});
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                reg_wr(rows[i].addr, rows[i].wdata);
            end else begin
                reg_expect(rows[i].addr, rows[i].exp);
            end
        end
        check8("divider port", 8'h13, {1'b0, nv_clock_div});
        $display("test register table done");
        // split sectors: same offsets, different bytes per page
        data_op(ER, 8'h05, 8'h00, 1'b0, rd_val);
        data_op(PG, 8'h04, 8'h12, 1'b0, rd_val);
        mem_expect(8'h04, 1'b0, 8'h12);
        reg_wr(`NV_OFS_CONFIGURATION, 8'h40);
        mem_expect(8'h04, 1'b0, 8'hFF);
        data_op(PG, 8'h07, 8'h34, 1'b0, rd_val);
        mem_expect(8'h07, 1'b0, 8'h34);
        data_op(ER, 8'h06, 8'h00, 1'b0, rd_val);
        reg_wr(`NV_OFS_CONFIGURATION, 8'h00);
        mem_expect(8'h04, 1'b0, 8'hFF);
        $display("test split sectors done");
        // secured: unsecured source blocked, status flag set
        data_op(PG, 8'h04, 8'h00, 1'b1, rd_val);
        mem_expect(8'h04, 1'b1, 8'h00);
        mem_expect(8'h04, 1'b0, 8'hFF);
        reg_expect(`NV_OFS_STATUS, 8'h01);
        reg_wr(`NV_OFS_STATUS, 8'h01);
        reg_expect(`NV_OFS_STATUS, 8'h00);
        $display("test secured access done");
        // key entry in reverse index order unsecures
        reg_wr(`NV_OFS_CONFIGURATION, 8'h20);
        // a wrong key first: flagged, still secured
        for (int i = 0; i < 8; i++) begin
            key_wr(3'(i), 8'h5A, rd_val);
        end
        repeat (2) @(posedge clk);
        reg_expect(`NV_OFS_STATUS, 8'h02);
        check8("secured", 8'h01, {7'h00, secured});
        for (int i = 7; i >= 0; i--) begin
            key_wr(3'(i), backdoor_compare_key[8*i +: 8], rd_val);
            check8("command start", 8'h00, rd_val);
        end
        wait_unsecured();
        reg_expect(`NV_OFS_OPTION_COPY, 8'h02);
        $display("test key entry done");
        // second reset: whole sectors, code 00, divider not written
        do_reset(8'h20);
        check8("secured", 8'h01, {7'h00, secured});
        reg_expect(`NV_OFS_CLOCK_DIVIDER, 8'h00);
        data_op(PG, 8'h08, 8'h00, 1'b0, rd_val);
        mem_expect(8'h08, 1'b0, 8'hFF);
        key_wr(3'h3, 8'hA5, rd_val);
        check8("command start", 8'h00, rd_val);
        reg_expect(`NV_OFS_STATUS, 8'h01);
        reg_wr(`NV_OFS_CLOCK_DIVIDER, 8'h13);
        $display("test divider gate done");
        // whole sectors: each page keeps its own sector
        data_op(ER, 8'h0C, 8'h00, 1'b0, rd_val);
        data_op(PG, 8'h08, 8'h11, 1'b0, rd_val);
        reg_wr(`NV_OFS_CONFIGURATION, 8'h40);
        data_op(ER, 8'h09, 8'h00, 1'b0, rd_val);
        data_op(PG, 8'h0F, 8'h22, 1'b0, rd_val);
        mem_expect(8'h0F, 1'b0, 8'h22);
        reg_wr(`NV_OFS_CONFIGURATION, 8'h00);
        mem_expect(8'h08, 1'b0, 8'h11);
        mem_expect(8'h0F, 1'b0, 8'hFF);
        $display("test whole sectors done");
        // key window write starts a command
        key_wr(3'h6, 8'hC3, rd_val);
        check8("command start", 8'h01, rd_val);
        check8("command index", 8'h06, {5'h00, cmd_index});
        check8("command data", 8'hC3, cmd_data);
        // blank check pass unsecures
        @(posedge clk);
        blank_check_pass <= 1'b1;
        @(posedge clk);
        blank_check_pass <= 1'b0;
        wait_unsecured();
        reg_expect(`NV_OFS_OPTION_COPY, 8'h22);
        $display("test command and blank check done");
        final_report();
    end
endmodule
